// ==== rtl/dts_core.sv ====
// dual channel temperature monitor core with smbus slave
// assumes the front end delivers signed quarter degree samples
`timescale 1ns/1ns
module dts_core
  import dts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            alert_n,
  input  wire logic       standby_in_n,
  input  wire logic [9:0] local_sample,
  input  wire logic [9:0] diode_anode_in,
  input  wire logic       diode_cathode_in,
  input  wire logic       diode_open_in,
  output logic            adc_active
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic scl_s, sda_s, standby_in_n_n_s, open_s, short_s;

  dts_sync u_scl (.clk(clk), .rst(rst), .d(scl_in), .q(scl_s));
  dts_sync u_sda (.clk(clk), .rst(rst), .d(sda_in), .q(sda_s));
  dts_sync u_stb (.clk(clk), .rst(rst), .d(standby_in_n),
                  .q(standby_in_n_n_s));
  // open detector is high while the remote diode path is broken
  dts_sync u_opn (.clk(clk), .rst(rst), .d(diode_open_in),
                  .q(open_s));
  dts_sync u_sht (.clk(clk), .rst(rst), .d(~diode_cathode_in),
                  .q(short_s));

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] cmd_q, cfg_q, rate_q, status_q;
  logic [7:0] local_q, remote_q;
  logic [7:0] upper_limit_q [2];
  logic [7:0] lower_limit_q [2];
  logic       alert_q, busy_q, rd_pending_q, wr_cmd_q, first_q;
  logic [7:0] tx_byte;
  logic       oneshot_req;

  // ************************************************************
  // smbus slave
  // ************************************************************
  logic       addr_hit, addr_rd, ara_hit, rx_valid;
  logic [7:0] rx_byte;
  logic       tx_done, tx_acked, stop_seen, start_seen;
  logic       slv_oe;

  dts_smbus_slave u_slv (
    .clk        (clk),
    .rst        (rst),
    .scl        (scl_s),
    .sda        (sda_s),
    .my_addr    (SLAVE_ADDR),
    .tx_byte    (tx_byte),
    .ara_want   (alert_q),
    .sda_oe     (slv_oe),
    .addr_hit   (addr_hit),
    .addr_rd    (addr_rd),
    .ara_hit    (ara_hit),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .tx_done    (tx_done),
    .tx_acked   (tx_acked),
    .stop_seen  (stop_seen),
    .start_seen (start_seen)
  );

  // read data mux, registers chosen by stored command byte
  logic ara_rd_q;
  always_comb begin
    tx_byte = 8'h00;
    if (ara_rd_q) begin
      tx_byte = {SLAVE_ADDR, 1'b1};
    end else if (cmd_q == CMD_LOCAL) begin
      tx_byte = local_q;
    end else if (cmd_q == CMD_REMOTE) begin
      tx_byte = remote_q;
    end else if (cmd_q == CMD_STATUS) begin
      tx_byte = status_q;
    end else if (cmd_q == CMD_CFG_RD) begin
      tx_byte = cfg_q;
    end else if (cmd_q == CMD_RATE_RD) begin
      tx_byte = rate_q;
    end else if (cmd_q == CMD_LHI_RD) begin
      tx_byte = upper_limit_q[0];
    end else if (cmd_q == CMD_LLO_RD) begin
      tx_byte = lower_limit_q[0];
    end else if (cmd_q == CMD_RHI_RD) begin
      tx_byte = upper_limit_q[1];
    end else if (cmd_q == CMD_RLO_RD) begin
      tx_byte = lower_limit_q[1];
    end
  end

  // first byte after a write address is the command, second data
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_cmd_q <= 1'b0;
      ara_rd_q <= 1'b0;
    end else begin
      if (addr_hit) begin
        wr_cmd_q <= ~addr_rd;
        ara_rd_q <= 1'b0;
      end else if (ara_hit) begin
        ara_rd_q <= 1'b1;
      end else if (rx_valid) begin
        wr_cmd_q <= 1'b0;
      end
      if (stop_seen) begin
        ara_rd_q <= 1'b0;
      end
    end
  end

  // command byte, one per address; short protocols reuse it
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= CMD_RESET;
    end else if (rx_valid && wr_cmd_q) begin
      cmd_q <= rx_byte;
    end
  end

  assign oneshot_req = rx_valid && wr_cmd_q && rx_byte == CMD_ONESHOT;

  // write byte data into the addressed register
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q  <= CFG_RESET;
      rate_q <= RATE_RESET;
      upper_limit_q[0] <= HI_RESET;
      upper_limit_q[1] <= HI_RESET;
      lower_limit_q[0] <= LO_RESET;
      lower_limit_q[1] <= LO_RESET;
    end else if (rx_valid && !wr_cmd_q) begin
      if (cmd_q == CMD_CFG_WR) begin
        cfg_q <= rx_byte;
      end else if (cmd_q == CMD_RATE_WR) begin
        rate_q <= rx_byte;
      end else if (cmd_q == CMD_LHI_WR) begin
        upper_limit_q[0] <= rx_byte;
      end else if (cmd_q == CMD_LLO_WR) begin
        lower_limit_q[0] <= rx_byte;
      end else if (cmd_q == CMD_RHI_WR) begin
        upper_limit_q[1] <= rx_byte;
      end else if (cmd_q == CMD_RLO_WR) begin
        lower_limit_q[1] <= rx_byte;
      end
    end
  end

  // ************************************************************
  // conversion sequencing
  // ************************************************************
  logic        hw_standby_in_n, sw_standby_in_n, conv_start, auto_due;
  logic [31:0] conv_cnt_q, rate_cnt_q;

  assign hw_standby_in_n  = ~standby_in_n_n_s;
  assign sw_standby_in_n  = cfg_q[CFG_STOP_BIT];
  assign auto_due = rate_cnt_q >= 32'(RATE_CYCLES - 1);
  // pin standby beats one-shot and the timer
  assign conv_start = !busy_q && !hw_standby_in_n
                      && (oneshot_req
                          || (!sw_standby_in_n && auto_due));

  always_ff @(posedge clk) begin
    if (rst) begin
      rate_cnt_q <= 32'h0;
    end else if (conv_start) begin
      rate_cnt_q <= 32'h0;
    end else if (!auto_due) begin
      rate_cnt_q <= rate_cnt_q + 32'h1;
    end
  end

  logic conv_done, abort;
  assign conv_done = busy_q && conv_cnt_q == 32'(CONV_CYCLES - 1);
  // pin standby, or software standby set after the start, cuts the conversion short, even on its last cycle
  assign abort = busy_q && (hw_standby_in_n || (sw_standby_in_n && !first_q));

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q     <= 1'b0;
      conv_cnt_q <= 32'h0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q     <= 1'b1;
      conv_cnt_q <= 32'h0;
    end else if (busy_q) begin
      conv_cnt_q <= conv_cnt_q + 32'h1;
      if (conv_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // a one-shot under software standby must not abort itself
  always_ff @(posedge clk) begin
    if (rst) begin
      first_q <= 1'b0;
    end else if (conv_start) begin
      first_q <= sw_standby_in_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      adc_active <= 1'b0;
    end else begin
      adc_active <= busy_q;
    end
  end

  // ************************************************************
  // result formatting
  // ************************************************************
  // quarter degree in, add half degree, truncate, saturate
  function automatic logic [7:0] fmt(input logic [9:0] s);
    logic [10:0] r;
    r = {s[9], s} + {3'h0, HALF_DEG};
    if ($signed(r) > $signed({TEMP_MAX, 2'h3})) begin
      fmt = TEMP_MAX;
    end else if ($signed(r[10:2]) < $signed(TEMP_MIN)) begin
      fmt = TEMP_MIN;
    end else begin
      fmt = r[9:2];
    end
  endfunction

  logic [7:0] loc_new, rem_new;
  assign loc_new = fmt(local_sample);
  assign rem_new = short_s ? fmt(diode_anode_in) : TEMP_ZERO;

  always_ff @(posedge clk) begin
    if (rst) begin
      local_q  <= TEMP_ZERO;
      remote_q <= TEMP_ZERO;
    end else if (conv_done && !abort) begin
      local_q  <= loc_new;
      remote_q <= rem_new;
    end
  end

  // ************************************************************
  // status and alert
  // ************************************************************
  logic lhi, llo, rhi, rlo, st_read;
  assign lhi = $signed(loc_new) >= $signed(upper_limit_q[0]);
  assign llo = $signed(loc_new) <= $signed(lower_limit_q[0]);
  assign rhi = $signed(rem_new) >= $signed(upper_limit_q[1]);
  assign rlo = $signed(rem_new) <= $signed(lower_limit_q[1]);
  assign st_read = tx_done && !ara_rd_q && cmd_q == CMD_STATUS;

  logic upd;
  assign upd = conv_done && !abort;

  // limit flags are sticky, busy is live; a new event wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
    end else begin
      if (st_read) begin
        status_q <= 8'h00;
      end
      status_q[ST_BUSY] <= busy_q;
      if (conv_start) begin
        status_q[ST_OPEN] <= open_s;
      end
      if (upd) begin
        status_q[ST_LHI] <= lhi | (status_q[ST_LHI] & !st_read);
        status_q[ST_LLO] <= llo | (status_q[ST_LLO] & !st_read);
        status_q[ST_RHI] <= rhi | (status_q[ST_RHI] & !st_read);
        status_q[ST_RLO] <= rlo | (status_q[ST_RLO] & !st_read);
      end
    end
  end

  logic alert_ev;
  assign alert_ev = (upd && (lhi || llo || rhi || rlo))
                    || (conv_start && open_s);

  always_ff @(posedge clk) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else if (alert_ev && !cfg_q[CFG_MASK_BIT]) begin
      alert_q <= 1'b1;
    end else if (tx_done && ara_rd_q) begin
      alert_q <= 1'b0;
    end
  end

  // ************************************************************
  // pin outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_n <= 1'b1;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      alert_n <= ~alert_q;
      sda_oe  <= slv_oe;
      sda_out <= 1'b0;
    end
  end
endmodule

// ==== rtl/dts_pkg.sv ====
// shared constants for the dual temperature sensor core
// assumes a 25 MHz system clock and a 10-bit measurement front end
package dts_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_HZ         = 25000000;
  localparam int CONV_TIME_MS   = 125;
  localparam int CONV_CYCLES    = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int RATE_PERIOD_MS = 1000;
  localparam int RATE_CYCLES    = CLK_HZ / 1000 * RATE_PERIOD_MS;

  // ************************************************************
  // addresses
  // ************************************************************
  localparam logic [6:0] ARA_ADDR   = 7'h0c;
  localparam logic [6:0] SLAVE_ADDR = 7'h18;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] CMD_LOCAL   = 8'h00;
  localparam logic [7:0] CMD_REMOTE  = 8'h01;
  localparam logic [7:0] CMD_STATUS  = 8'h02;
  localparam logic [7:0] CMD_CFG_RD  = 8'h03;
  localparam logic [7:0] CMD_RATE_RD = 8'h04;
  localparam logic [7:0] CMD_LHI_RD  = 8'h05;
  localparam logic [7:0] CMD_LLO_RD  = 8'h06;
  localparam logic [7:0] CMD_RHI_RD  = 8'h07;
  localparam logic [7:0] CMD_RLO_RD  = 8'h08;
  localparam logic [7:0] CMD_CFG_WR  = 8'h09;
  localparam logic [7:0] CMD_RATE_WR = 8'h0a;
  localparam logic [7:0] CMD_LHI_WR  = 8'h0b;
  localparam logic [7:0] CMD_LLO_WR  = 8'h0c;
  localparam logic [7:0] CMD_RHI_WR  = 8'h0d;
  localparam logic [7:0] CMD_RLO_WR  = 8'h0e;
  localparam logic [7:0] CMD_ONESHOT = 8'h0f;

  // ************************************************************
  // reset values and fields
  // ************************************************************
  localparam logic [7:0] HI_RESET   = 8'h7f;
  localparam logic [7:0] LO_RESET   = 8'hc9;
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h02;
  localparam logic [7:0] TEMP_MAX   = 8'h7f;
  localparam logic [7:0] TEMP_MIN   = 8'hbf;
  localparam logic [7:0] TEMP_ZERO  = 8'h00;
  localparam logic [7:0] HALF_DEG   = 8'h02;
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STOP_BIT = 6;
  localparam int ST_BUSY      = 7;
  localparam int ST_LHI       = 6;
  localparam int ST_LLO       = 5;
  localparam int ST_RHI       = 4;
  localparam int ST_RLO       = 3;
  localparam int ST_OPEN      = 2;

  typedef enum logic [1:0] {
    DTS_XF_NONE, DTS_XF_WRITE, DTS_XF_CMD, DTS_XF_READ
  } dts_xfer_t;
endpackage

// ==== rtl/dts_sync.sv ====
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ns
module dts_sync
  import dts_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== rtl/dts_smbus_slave.sv ====
// byte level smbus slave: start, stop, address, bytes, acks
// assumes sda and scl are already synchronised to clk
`timescale 1ns/1ns
module dts_smbus_slave
  import dts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] my_addr,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ara_want,
  output logic            sda_oe,
  output logic            addr_hit,
  output logic            addr_rd,
  output logic            ara_hit,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_done,
  output logic            tx_acked,
  output logic            stop_seen,
  output logic            start_seen
);
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ACK, SL_RX, SL_TX, SL_TXACK
  } dts_sl_t;

  dts_sl_t    st_q;
  logic       scl_q, sda_q, rd_q, ara_q, after_addr_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       scl_rise, scl_fall;

  assign scl_rise   = scl & ~scl_q;
  assign scl_fall   = ~scl & scl_q;
  assign start_seen = scl & scl_q & sda_q & ~sda;
  assign stop_seen  = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // frame: start, address and r/w, ack, bytes, ack or nack
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= SL_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00;
      rd_q <= 1'b0; ara_q <= 1'b0; after_addr_q <= 1'b0;
      sda_oe <= 1'b0; addr_hit <= 1'b0; addr_rd <= 1'b0;
      ara_hit <= 1'b0; rx_valid <= 1'b0; rx_byte <= 8'h00;
      tx_done <= 1'b0; tx_acked <= 1'b0;
    end else begin
      addr_hit <= 1'b0; ara_hit <= 1'b0;
      rx_valid <= 1'b0; tx_done <= 1'b0;
      if (start_seen) begin
        st_q <= SL_ADDR; cnt_q <= 4'h0; sda_oe <= 1'b0;
      end else if (stop_seen) begin
        st_q <= SL_IDLE; sda_oe <= 1'b0;
      end else begin
        case (st_q)
          SL_ADDR, SL_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == SL_RX) begin
                rx_valid <= 1'b1; rx_byte <= sh_q;
                sda_oe <= 1'b1; st_q <= SL_ACK; after_addr_q <= 1'b0;
              end else if (sh_q[7:1] == my_addr) begin
                rd_q <= sh_q[0]; ara_q <= 1'b0;
                addr_hit <= 1'b1; addr_rd <= sh_q[0];
                sda_oe <= 1'b1; st_q <= SL_ACK; after_addr_q <= 1'b1;
              end else if (sh_q[7:1] == ARA_ADDR && sh_q[0]
                           && ara_want) begin
                rd_q <= 1'b1; ara_q <= 1'b1; ara_hit <= 1'b1;
                sda_oe <= 1'b1; st_q <= SL_ACK; after_addr_q <= 1'b1;
              end else begin
                st_q <= SL_IDLE;
              end
            end
          end
          SL_ACK: begin
            if (scl_fall) begin
              if (rd_q && after_addr_q) begin
                st_q <= SL_TX;
                sh_q <= tx_byte;
                sda_oe <= ~tx_byte[7];
                cnt_q <= 4'h1;
              end else begin
                st_q <= SL_RX; sda_oe <= 1'b0;
              end
            end
          end
          SL_TX: begin
            // msb first; open drain so drive only zeros
            if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe <= 1'b0; st_q <= SL_TXACK;
              end else begin
                sda_oe <= ~sh_q[3'd7 - cnt_q[2:0]];
                cnt_q  <= cnt_q + 4'h1;
              end
            end
          end
          SL_TXACK: begin
            if (scl_rise) begin
              tx_done <= 1'b1; tx_acked <= ~sda;
              st_q <= SL_IDLE;
            end
          end
          default: st_q <= SL_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== bench/dts_core_properties.sv ====
// pin level checker for the temperature core
// assumes it is bound onto dts_core, one clock domain
`timescale 1ns/1ns
module dts_core_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_n,
  input wire logic standby_in_n,
  input wire logic adc_active
);
  // ************************************************************
  // helper counters
  // ************************************************************
  logic [7:0] oe_gap_q;
  logic [3:0] lo_cnt_q;

  // cycles since the slave last pulled sda
  always_ff @(posedge clk) begin
    if (rst) oe_gap_q <= 8'hff;
    else if (sda_oe) oe_gap_q <= 8'h00;
    else if (oe_gap_q != 8'hff) oe_gap_q <= oe_gap_q + 8'h01;
  end

  // consecutive low samples of the standby pin, saturating
  always_ff @(posedge clk) begin
    if (rst || standby_in_n) lo_cnt_q <= 4'h0;
    else if (lo_cnt_q != 4'hf) lo_cnt_q <= lo_cnt_q + 4'h1;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_sda_out_zero: assert property (
    @(posedge clk) disable iff (rst) sda_out == 1'b0)
    else $error("sda driven high");
  a_ack_scl_low: assert property (
    @(posedge clk) disable iff (rst) $rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_release_scl_low: assert property (
    @(posedge clk) disable iff (rst) $fell(sda_oe) |-> !scl_in)
    else $error("sda released while scl high");
  a_sda_hold_high: assert property (
    @(posedge clk) disable iff (rst)
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved during scl high");
  a_hw_standby_idle: assert property (
    @(posedge clk) disable iff (rst) lo_cnt_q >= 4'h8 |-> !adc_active)
    else $error("converter active in hardware standby");
  a_standby_no_start: assert property (
    @(posedge clk) disable iff (rst)
    (!standby_in_n) [*8] |=> !$rose(adc_active))
    else $error("conversion started with standby pin low");
  a_reset_outputs: assert property (
    @(posedge clk) rst |=> alert_n && !sda_oe && !adc_active)
    else $error("outputs not idle after reset");
  a_alert_clear_ara: assert property (
    @(posedge clk) disable iff (rst) $rose(alert_n) |-> oe_gap_q <= 8'hc0)
    else $error("alert cleared without a response read");

  c_conv_start: cover property (@(posedge clk) $rose(adc_active));
  c_alert_set: cover property (@(posedge clk) $fell(alert_n));
  c_alert_clear: cover property (@(posedge clk) $rose(alert_n));
endmodule

bind dts_core dts_core_properties u_dts_core_properties (
  .clk          (clk),
  .rst          (rst),
  .scl_in       (scl_in),
  .sda_out      (sda_out),
  .sda_oe       (sda_oe),
  .alert_n      (alert_n),
  .standby_in_n (standby_in_n),
  .adc_active   (adc_active)
);

// ==== bench/dts_host_model.sv ====
// behavioural smbus host for the temperature core
// assumes an open drain sda with pull-up, scl idles high
`timescale 1ns/1ns
module dts_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // ************************************************************
  // bit and frame tasks
  // ************************************************************
  // scl low 5 clk, high 3 clk: one 320 ns period; the slave
  // answers 4 clk after scl falls, still inside the low phase
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // sda changes only mid low phase, read mid high phase
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(2);
    s = sda;
    tick(1);
    scl = 1'b0;
  endtask

  task automatic start_cond();
    if (!scl) begin
      tick(2);
      sda_pull = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(4);
    end
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(2);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // kind 0 send, 1 write, 2 read, 3 receive; a read ends with nack
  // receive relies on the stored command: single host only
  task automatic xfer(input logic [6:0] a, input logic [1:0] kind,
                      input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    logic k;
    logic s;
    ok = 1'b1;
    rd = 8'h00;
    start_cond();
    if (kind != 2'd3) begin
      put_byte({a, 1'b0}, k);
      ok &= k;
      put_byte(cmd, k);
      ok &= k;
      if (kind == 2'd1) put_byte(wd, k);
      if (kind == 2'd1) ok &= k;
      if (kind == 2'd2) start_cond();
    end
    if (kind[1]) begin
      put_byte({a, 1'b1}, k);
      ok &= k;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rd[i]);
      bit_io(1'b1, s);
    end
    stop_cond();
  endtask
endmodule

// ==== bench/dts_core_test.sv ====
// self-checking bench for the temperature core
// assumes dts_host_model as bus partner; conversions never finish here
`timescale 1ns/1ns
module dts_core_test;
  import dts_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       standby_in_n = 1'b0;
  logic       diode_open_in = 1'b1;
  logic [9:0] local_sample = 10'h064;
  logic [9:0] diode_anode_in = 10'h0a2;
  logic       diode_cathode_in = 1'b0;
  wire logic  scl;
  wire logic  sda_pull;
  wire logic  sda_out;
  wire logic  sda_oe;
  wire logic  alert_n;
  wire logic  adc_active;
  wire logic  sda = ~(sda_pull | (sda_oe & ~sda_out));
  int         error_cnt = 0;
  int         n_checks = 0;
  logic [7:0] rd;
  logic       ok;

  always #20 clk = ~clk;

  dts_core u_dts_core (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_n(alert_n),
    .standby_in_n(standby_in_n), .local_sample(local_sample),
    .diode_anode_in(diode_anode_in), .diode_cathode_in(diode_cathode_in),
    .diode_open_in(diode_open_in), .adc_active(adc_active));
  dts_host_model u_dts_host_model (.clk(clk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic xf(input logic [1:0] kind, input logic [7:0] cmd,
                    input logic [7:0] wd);
    u_dts_host_model.xfer(SLAVE_ADDR, kind, cmd, wd, rd, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_reg(input logic [7:0] cmd, input logic [7:0] exp);
    xf(2'd2, cmd, 8'h00);
    check(rd, exp);
  endtask

  // bounded wait; running out ends the run
  task automatic wait_active(input logic exp);
    int i;
    i = 0;
    while (adc_active !== exp && i < 200) begin
      step(1);
      i++;
    end
    check({7'h00, adc_active}, {7'h00, exp});
    if (adc_active !== exp) give_verdict();
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_defaults();
    xf(2'd3, 8'h00, 8'h00);
    check(rd, 8'h00);
    rd_reg(CMD_LHI_RD, 8'h7f);
    rd_reg(CMD_LLO_RD, 8'hc9);
    rd_reg(CMD_RHI_RD, 8'h7f);
    rd_reg(CMD_RLO_RD, 8'hc9);
    xf(2'd3, 8'h00, 8'h00);
    check(rd, 8'hc9);
    rd_reg(CMD_STATUS, 8'h00);
    u_dts_host_model.xfer(SLAVE_ADDR ^ 7'h01, 2'd2, CMD_LHI_RD, 8'h00,
                          rd, ok);
    check({7'h00, ok}, 8'h00);
    $display("defaults test done");
  endtask

  task automatic t_hw_block();
    xf(2'd0, CMD_ONESHOT, 8'h00);
    step(40);
    check({7'h00, adc_active}, 8'h00);
    rd_reg(CMD_STATUS, 8'h00);
    $display("hardware standby test done");
  endtask

  task automatic t_limits();
    for (int i = 0; i < 4; i++) begin
      xf(2'd1, CMD_LHI_WR + i[7:0], 8'h81 + i[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      rd_reg(CMD_LHI_RD + i[7:0], 8'h81 + i[7:0]);
    end
    $display("limit register test done");
  endtask

  task automatic t_oneshot();
    xf(2'd1, CMD_CFG_WR, 8'h40);
    standby_in_n = 1'b1;
    step(40);
    check({7'h00, adc_active}, 8'h00);
    xf(2'd0, CMD_ONESHOT, 8'h00);
    wait_active(1'b1);
    rd_reg(CMD_STATUS, 8'h84);
    check({7'h00, alert_n}, 8'h00);
    u_dts_host_model.xfer(ARA_ADDR, 2'd3, 8'h00, 8'h00, rd, ok);
    check(rd, {SLAVE_ADDR, 1'b1});
    check({7'h00, ok}, 8'h01);
    step(8);
    check({7'h00, alert_n}, 8'h01);
    $display("one-shot test done");
  endtask

  task automatic t_abort();
    standby_in_n = 1'b0;
    wait_active(1'b0);
    rd_reg(CMD_LOCAL, 8'h00);
    rd_reg(CMD_REMOTE, 8'h00);
    $display("abort test done");
  endtask

  initial begin
    step(5);
    rst = 1'b0;
    step(10);
    t_defaults();
    t_hw_block();
    t_limits();
    t_oneshot();
    t_abort();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
